// File: pxa_cfg.svh
// Constants for the port expander address and port configuration block
// What this block does
// - Answer address 110 plus four select bits
// - Redecode the address on every bus transmission
// - Tell data, clock, high or low ties apart
// - Before first transmission use static level only
// - Low select sets pullups 2-3, outputs 0-1
// - High select sets pullups 4-5, outputs 6-7
// - High, data or clock tie means high
// - Map select classes onto address bits A3..A0
// - First read byte returns pin levels latched at the acknowledge
// - Second read byte returns transition flags, zeros
// - Written byte sets all eight ports together
// - Address acknowledge clears flags and releases alert
`ifndef PXA_CFG_SVH
`define PXA_CFG_SVH
`define PXA_ADDR_FIXED 3'h6
`define PXA_BYTE_BITS  4'h8
`define PXA_INIT_WAIT  3'h4
`define PXA_OD_LSB     2
`define PXA_OD_MSB     5
`define PXA_OUT_RST    8'hff
`define PXA_PULL_RST   4'hf
`define PXA_SNAP_RST   4'hf
`define PXA_A_HI_SCL   2'h0
`define PXA_A_HI_SDA   2'h1
`define PXA_A_HI_LOW   2'h2
`define PXA_A_HI_HIGH  2'h3
`define PXA_A_LO_LOW   2'h0
`define PXA_A_LO_HIGH  2'h1
`define PXA_A_LO_SCL   2'h2
`define PXA_A_LO_SDA   2'h3
`endif

// File: pxa_i2c_master.sv
// Behavioural bus master that frames transfers for the expander
`timescale 1ns/1ps
module pxa_i2c_master (
  // Clock
  input wire logic clk_sys,
  // Bus lines, data released when sda_o is high
  input wire logic sda,
  output logic     scl_o,
  output logic     sda_o
);
  localparam int Q = 10;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tk;
    repeat (Q) @(posedge clk_sys);
    #1;
  endtask
  // Also serves as repeated start from a low clock
  task automatic start;
    sda_o = 1'b1;
    tk();
    scl_o = 1'b1;
    tk();
    sda_o = 1'b0;
    tk();
    scl_o = 1'b0;
    tk();
  endtask
  task automatic stop;
    sda_o = 1'b0;
    tk();
    scl_o = 1'b1;
    tk();
    sda_o = 1'b1;
    tk();
  endtask
  // Data held steady while the clock is high
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    tk();
    scl_o = 1'b1;
    tk();
    r = sda;
    tk();
    scl_o = 1'b0;
    tk();
  endtask
  task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(a, k);
  endtask
endmodule // pxa_i2c_master

// File: pxa_pkg.sv
// Types shared by the port expander address and port configuration block
package pxa_pkg;

  typedef enum logic [1:0] {
    pxa_cls_low,
    pxa_cls_high,
    pxa_cls_scl,
    pxa_cls_sda
  } pxa_cls_t;

  typedef enum logic [2:0] {
    pxa_idle,
    pxa_addr,
    pxa_addr_ack,
    pxa_wr,
    pxa_wr_ack,
    pxa_rd,
    pxa_rd_ack,
    pxa_skip
  } pxa_fsm_t;

  typedef struct packed {
    logic     tx_seen;
    logic     dsda;
    logic     dscl;
    logic     scl_fell;
    logic     sda_rose;
    logic     scl_p;
    logic     sda_p;
    pxa_cls_t cls;
  } pxa_cls_st_t;

  typedef struct packed {
    pxa_fsm_t    fsm;
    logic        scl_m, scl_s, scl_p;
    logic        sda_m, sda_s, sda_p;
    logic        lo_m, lo_s, hi_m, hi_s;
    logic [3:0]  od_m, od_s;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  tx;
    logic        rw, mack, pair, wr_done, rd_frame;
    logic [2:0]  init_cnt;
    logic        init_done;
    logic [7:0]  out;
    logic [3:0]  snap, flags, pull, od_oe, od_o;
    logic        alert, sda_oe, sda_o;
    logic [6:0]  addr;
    logic        busy;
  } pxa_st_t;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] drive;
    logic [3:0] drive_oe;
    logic [3:0] pullup_en;
  } pxa_od_t;

endpackage

// File: pxa_properties.sv
// Checker for the expander bus, address and pullup outputs
`timescale 1ns/1ps
module pxa_properties (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Bus and status
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       bus_busy,
  input wire logic [6:0] slave_addr,
  // Ports
  input wire logic [3:0] open_drain_ports_out,
  input wire logic [3:0] pullup_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_addr_fixed: assert property (!$past(rst) |-> slave_addr[6:4] == 3'h6)
    else $error("slave address top bits wrong");
  a_sda_low: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_od_low: assert property (open_drain_ports_out == 4'h0)
    else $error("open-drain port driven high");
  a_oe_frame: assert property (sda_oe |-> bus_busy)
    else $error("data line pulled outside a frame");
  a_start_seen: assert property ($rose(bus_busy) |-> $past(scl_in, 2) && !$past(sda_in, 2))
    else $error("frame began without a start");
  a_pull_pairs: assert property (pullup_en[3] == pullup_en[2] && pullup_en[1] == pullup_en[0])
    else $error("pullups not set in pairs");
  a_pull_high: assert property ((!bus_busy && $stable(slave_addr)) [*8]
    |-> pullup_en[3:2] == {2{slave_addr[3:2] != 2'h2}})
    else $error("high pullups disagree with address");
  a_pull_low: assert property ((!bus_busy && $stable(slave_addr)) [*8]
    |-> pullup_en[1:0] == {2{slave_addr[1:0] != 2'h0}})
    else $error("low pullups disagree with address");
endmodule // pxa_properties

bind pxa_top pxa_properties u_props (.clk_sys, .rst, .scl_in, .sda_in, .sda_out, .sda_oe,
  .bus_busy, .slave_addr, .open_drain_ports_out, .pullup_en);

// File: pxa_sel_class.sv
// Classifies one four-level address select input
`timescale 1ns/1ps
`include "pxa_cfg.svh"
module pxa_sel_class (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Synchronised levels
  input  wire logic             sel,
  input  wire logic             sda,
  input  wire logic             scl,
  // Frame markers
  input  wire logic             frame_start,
  input  wire logic             in_frame,
  // Result
  output pxa_pkg::pxa_cls_t     cls
);
  import pxa_pkg::*;

  pxa_cls_st_t q;
  pxa_cls_st_t n;

  assign cls = q.cls;

  always_comb begin
    logic nd_sda;
    logic nd_scl;
    nd_sda = q.dsda | (sel ^ sda);
    nd_scl = q.dscl | (sel ^ scl);
    n = q;
    n.scl_p = scl;
    n.sda_p = sda;
    if (frame_start) begin
      n.dsda = 1'b0;
      n.dscl = 1'b0;
      n.scl_fell = 1'b0;
      n.sda_rose = 1'b0;
    end else if (in_frame) begin
      n.tx_seen = 1'b1;
      n.dsda = nd_sda;
      n.dscl = nd_scl;
      n.scl_fell = q.scl_fell | (q.scl_p & ~scl);
      n.sda_rose = q.sda_rose | (~q.sda_p & sda);
      // A pin that has tracked a line through its own edges is tied to it
      if (n.scl_fell && !n.dscl) begin
        n.cls = pxa_cls_scl;
      end else if (n.sda_rose && !n.dsda) begin
        n.cls = pxa_cls_sda;
      end else begin
        n.cls = sel ? pxa_cls_high : pxa_cls_low;
      end
    end else if (!q.tx_seen) begin
      n.cls = sel ? pxa_cls_high : pxa_cls_low;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '{scl_p: 1'b1, sda_p: 1'b1, cls: pxa_cls_high, default: '0};
    end else begin
      q <= n;
    end
  end

endmodule // pxa_sel_class

// File: pxa_top.sv
// Serial-bus port expander: address decode, port setup, read and write bytes
`timescale 1ns/1ps
`include "pxa_cfg.svh"
module pxa_top (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Address select pins
  input  wire logic       addr_sel_low_in,
  input  wire logic       addr_sel_high_in,
  // Open-drain ports 5..2
  input  wire logic [3:0] open_drain_ports_in,
  output logic      [3:0] open_drain_ports_out,
  output logic      [3:0] open_drain_ports_oe,
  output logic      [3:0] pullup_en,
  // Push-pull outputs
  output logic            pushpull_out_7,
  output logic            pushpull_out_6,
  output logic            pushpull_out_1,
  output logic            pushpull_out_0,
  // Status
  output logic            chg_alert,
  output logic      [6:0] slave_addr,
  output logic            bus_busy
);
  import pxa_pkg::*;

  pxa_st_t  q;
  pxa_st_t  n;
  pxa_cls_t cls_lo;
  pxa_cls_t cls_hi;
  logic     start;
  logic     stop;
  logic     rise;
  logic     fall;
  logic     in_frame;
  logic [3:0] chg;
  logic [6:0] my_addr;
  logic [7:0] dflt;
  logic     g_lo;
  logic     g_hi;

  function automatic logic [1:0] addr_hi_bits(input pxa_cls_t c);
    unique case (c)
      pxa_cls_scl:  addr_hi_bits = `PXA_A_HI_SCL;
      pxa_cls_sda:  addr_hi_bits = `PXA_A_HI_SDA;
      pxa_cls_low:  addr_hi_bits = `PXA_A_HI_LOW;
      pxa_cls_high: addr_hi_bits = `PXA_A_HI_HIGH;
    endcase
  endfunction

  function automatic logic [1:0] addr_lo_bits(input pxa_cls_t c);
    unique case (c)
      pxa_cls_low:  addr_lo_bits = `PXA_A_LO_LOW;
      pxa_cls_high: addr_lo_bits = `PXA_A_LO_HIGH;
      pxa_cls_scl:  addr_lo_bits = `PXA_A_LO_SCL;
      pxa_cls_sda:  addr_lo_bits = `PXA_A_LO_SDA;
    endcase
  endfunction

  // Anything but a low tie counts as a high group
  function automatic logic grp_high(input pxa_cls_t c);
    grp_high = (c != pxa_cls_low);
  endfunction

  // Read-back byte: push-pull 7,6, open-drain 5..2, push-pull 1,0
  function automatic logic [7:0] port_byte(input logic [7:0] o, input logic [3:0] od);
    port_byte = {o[7:6], od, o[1:0]};
  endfunction

  // One classifier for each select pin
  pxa_sel_class u_cls_lo (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .sel         (q.lo_s),
    .sda         (q.sda_s),
    .scl         (q.scl_s),
    .frame_start (start),
    .in_frame    (in_frame),
    .cls         (cls_lo)
  );

  pxa_sel_class u_cls_hi (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .sel         (q.hi_s),
    .sda         (q.sda_s),
    .scl         (q.scl_s),
    .frame_start (start),
    .in_frame    (in_frame),
    .cls         (cls_hi)
  );

  // Bus conditions seen on the synchronised lines
  assign start    = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign stop     = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
  assign rise     = q.scl_s & ~q.scl_p;
  assign fall     = ~q.scl_s & q.scl_p;
  assign in_frame = (q.fsm != pxa_idle);
  assign chg      = q.od_s ^ q.snap;
  assign g_lo     = grp_high(cls_lo);
  assign g_hi     = grp_high(cls_hi);
  // Address follows the classes of the current transmission
  assign my_addr  = {`PXA_ADDR_FIXED, addr_hi_bits(cls_hi), addr_lo_bits(cls_lo)};
  assign dflt     = {{4{g_hi}}, {4{g_lo}}};

  always_comb begin
    logic clr;
    clr = 1'b0;
    n = q;
    // Two-stage synchronisers for every pin input
    n.scl_m = scl_in;
    n.scl_s = q.scl_m;
    n.scl_p = q.scl_s;
    n.sda_m = sda_in;
    n.sda_s = q.sda_m;
    n.sda_p = q.sda_s;
    n.lo_m  = addr_sel_low_in;
    n.lo_s  = q.lo_m;
    n.hi_m  = addr_sel_high_in;
    n.hi_s  = q.hi_m;
    n.od_m  = open_drain_ports_in;
    n.od_s  = q.od_m;
    n.addr  = my_addr;

    // Pullups track the select classes
    n.pull = {{2{g_hi}}, {2{g_lo}}};

    // Power-up levels are taken once the classifiers have settled
    if (!q.init_done) begin
      n.init_cnt = q.init_cnt + 3'h1;
      if (q.init_cnt == `PXA_INIT_WAIT) begin
        n.init_done = 1'b1;
        n.out = dflt;
      end
    end

    // A start or stop overrides whatever the frame was doing
    if (start) begin
      n.fsm    = pxa_addr;
      n.cnt    = 4'h0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.fsm      = pxa_idle;
      n.sda_oe   = 1'b0;
      n.rd_frame = 1'b0;
    end else begin
      unique case (q.fsm)
        pxa_idle, pxa_skip: begin
        end
        pxa_addr: begin
          // Seven address bits, then the direction bit
          if (rise) begin
            n.sh  = {q.sh[6:0], q.sda_s};
            n.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == `PXA_BYTE_BITS) begin
            if (q.sh[7:1] == my_addr) begin
              n.fsm      = pxa_addr_ack;
              n.sda_oe   = 1'b1;
              n.rw       = q.sh[0];
              n.rd_frame = q.rd_frame | q.sh[0];
              n.wr_done  = 1'b0;
              clr        = 1'b1;
            end else begin
              n.fsm = pxa_skip;
            end
          end
        end
        pxa_addr_ack: begin
          if (fall) begin
            n.cnt = 4'h0;
            if (q.rw) begin
              n.fsm    = pxa_rd;
              n.tx     = port_byte(q.out, q.snap);
              n.sda_oe = ~q.out[7];
              n.pair   = 1'b1;
            end else begin
              n.fsm    = pxa_wr;
              n.sda_oe = 1'b0;
            end
          end
        end
        pxa_wr: begin
          if (rise) begin
            n.sh  = {q.sh[6:0], q.sda_s};
            n.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == `PXA_BYTE_BITS) begin
            // Only the first data byte drives the ports
            if (!q.wr_done) begin
              n.out       = q.sh;
              n.wr_done   = 1'b1;
              n.init_done = 1'b1;
            end
            n.fsm    = pxa_wr_ack;
            n.sda_oe = 1'b1;
          end
        end
        pxa_wr_ack: begin
          if (fall) begin
            n.fsm    = pxa_wr;
            n.sda_oe = 1'b0;
            n.cnt    = 4'h0;
          end
        end
        pxa_rd: begin
          if (rise) begin
            n.cnt = q.cnt + 4'h1;
          end else if (fall) begin
            if (q.cnt == `PXA_BYTE_BITS) begin
              n.fsm    = pxa_rd_ack;
              n.sda_oe = 1'b0;
            end else begin
              // Next bit goes out just after the clock falls
              n.tx     = {q.tx[6:0], 1'b0};
              n.sda_oe = ~q.tx[6];
            end
          end
        end
        pxa_rd_ack: begin
          // Master acknowledge is taken while the clock is high
          if (rise) begin
            n.mack = ~q.sda_s;
          end else if (fall) begin
            if (q.mack) begin
              n.fsm = pxa_rd;
              n.cnt = 4'h0;
              if (q.pair) begin
                n.tx     = {2'h0, q.flags, 2'h0};
                // Flags byte opens with a zero bit, so the line is pulled low
                n.sda_oe = 1'b1;
                n.pair   = 1'b0;
              end else begin
                // Long read: resample and restart flags for each pair
                clr      = 1'b1;
                n.tx     = port_byte(q.out, q.od_s);
                n.sda_oe = ~q.out[7];
                n.pair   = 1'b1;
              end
            end else begin
              n.fsm = pxa_skip;
            end
          end
        end
      endcase
    end

    // Clearing takes a fresh snapshot; a later change shows against it next cycle
    if (clr) begin
      n.flags = 4'h0;
      n.snap  = q.od_s;
      n.alert = 1'b0;
    end else begin
      n.flags = q.flags | chg;
      // Inside a read the alert is held back until the stop
      if (|chg && !q.rd_frame) begin
        n.alert = 1'b1;
      end
    end
    if (stop && q.rd_frame) begin
      n.alert = q.alert | (|n.flags);
    end

    // A port written low is driven; a high leaves it to the pullup
    n.od_oe = ~n.out[`PXA_OD_MSB:`PXA_OD_LSB];
    n.busy  = (n.fsm != pxa_idle);
  end

  // Bus synchronisers reset to the idle-high level so no false start follows
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '{fsm:   pxa_idle,
             scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
             sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
             out:   `PXA_OUT_RST,
             pull:  `PXA_PULL_RST,
             snap:  `PXA_SNAP_RST,
             default: '0};
    end else begin
      q <= n;
    end
  end

  // Every output comes straight from the state register
  assign sda_out              = q.sda_o;
  assign sda_oe               = q.sda_oe;
  assign open_drain_ports_out = q.od_o;
  assign open_drain_ports_oe  = q.od_oe;
  assign pullup_en            = q.pull;
  assign pushpull_out_7       = q.out[7];
  assign pushpull_out_6       = q.out[6];
  assign pushpull_out_1       = q.out[1];
  assign pushpull_out_0       = q.out[0];
  assign chg_alert            = q.alert;
  assign slave_addr           = q.addr;
  assign bus_busy             = q.busy;

endmodule // pxa_top

// File: pxa_top_tb.sv
// Self-checking bench for the expander address and port setup
`timescale 1ns/1ps
module pxa_top_tb;
  import pxa_pkg::*;
  typedef struct packed {
    logic [1:0] hi, lo;
    logic [7:0] d;
    logic [6:0] a;
    logic [3:0] pu;
  } pxa_row_t;
  // Select ties: 0 low, 1 high, 2 bus clock, 3 bus data
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] m_hi = 2'h1, m_lo = 2'h1;
  logic [3:0] ext = 4'hf;
  logic       m_scl, m_sda, sda_out, sda_oe, chg_alert, bus_busy;
  logic       pushpull_out_7, pushpull_out_6, pushpull_out_1, pushpull_out_0;
  logic [3:0] open_drain_ports_out, open_drain_ports_oe, pullup_en;
  logic [6:0] slave_addr;
  int         num_errors = 0, checks = 0;
  wire        scl_in = m_scl;
  wire        sda_in = m_sda & ~sda_oe;
  wire  [3:0] open_drain_ports_in = ext & ~open_drain_ports_oe;
  wire        addr_sel_low_in = m_lo[1] ? (m_lo[0] ? sda_in : scl_in) : m_lo[0];
  wire        addr_sel_high_in = m_hi[1] ? (m_hi[0] ? sda_in : scl_in) : m_hi[0];
  wire  [7:0] pp = {pushpull_out_7, pushpull_out_6, ~open_drain_ports_oe,
                    pushpull_out_1, pushpull_out_0};
  pxa_row_t   rows [8] = '{'{2'h2, 2'h0, 8'h5a, 7'h60, 4'hc}, '{2'h3, 2'h1, 8'ha5, 7'h65, 4'hf},
                           '{2'h0, 2'h2, 8'h3c, 7'h6a, 4'h3}, '{2'h1, 2'h3, 8'hc3, 7'h6f, 4'hf},
                           '{2'h0, 2'h0, 8'h00, 7'h68, 4'h0}, '{2'h1, 2'h1, 8'hff, 7'h6d, 4'hf},
                           '{2'h2, 2'h3, 8'h81, 7'h63, 4'hf}, '{2'h3, 2'h2, 8'h7e, 7'h66, 4'hf}};
  pxa_top u_dut (.clk_sys, .rst, .scl_in, .sda_in, .sda_out, .sda_oe, .addr_sel_low_in,
    .addr_sel_high_in, .open_drain_ports_in, .open_drain_ports_out, .open_drain_ports_oe,
    .pullup_en, .pushpull_out_7, .pushpull_out_6, .pushpull_out_1, .pushpull_out_0,
    .chg_alert, .slave_addr, .bus_busy);
  pxa_i2c_master u_mst (.clk_sys, .sda(sda_in), .scl_o(m_scl), .sda_o(m_sda));
  always #2.5 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Reads leave the frame open for the data bytes
  task automatic frame(input logic [6:0] a, input logic rd, input logic [7:0] d, output logic k);
    logic [7:0] r;
    logic       k2;
    u_mst.start();
    u_mst.xfer({a, rd}, 1'b1, r, k);
    if (!k && !rd) u_mst.xfer(d, 1'b1, r, k2);
    if (!rd) u_mst.stop();
  endtask
  initial begin
    logic       k;
    logic [7:0] r;
    cyc(8);
    rst = 1'b0;
    cyc(10);
    foreach (rows[i]) begin
      m_hi = rows[i].hi;
      m_lo = rows[i].lo;
      cyc(4);
      frame(rows[i].a ^ 7'h10, 1'b0, 8'h00, k);
      chk(k, 1'b1);
      chk(slave_addr, rows[i].a);
      chk(pullup_en, rows[i].pu);
      frame(rows[i].a, 1'b0, rows[i].d, k);
      chk(k, 1'b0);
      chk(pp, rows[i].d);
    end
    // Port change while idle, then a two-byte read
    ext = 4'hd;
    for (int i = 0; i < 40 && chg_alert !== 1'b1; i++) cyc(1);
    chk(chg_alert, 1'b1);
    if (chg_alert !== 1'b1) end_sim();
    frame(7'h66, 1'b1, 8'h00, k);
    chk(k, 1'b0);
    chk(chg_alert, 1'b0);
    fork
      u_mst.xfer(8'hff, 1'b0, r, k);
      begin
        cyc(100);
        ext = 4'h9;
      end
    join
    chk(r, 8'h76);
    u_mst.xfer(8'hff, 1'b1, r, k);
    chk(r, 8'h10);
    chk(chg_alert, 1'b0);
    u_mst.stop();
    // Power-up with the high select tied to the bus clock
    m_hi = 2'h2;
    m_lo = 2'h0;
    ext = 4'hf;
    rst = 1'b1;
    cyc(2);
    chk({pullup_en, chg_alert, sda_oe}, 6'h3c);
    chk(pp, 8'hff);
    cyc(6);
    rst = 1'b0;
    cyc(10);
    chk(slave_addr, 7'h6c);
    chk(pullup_en, 4'hc);
    chk(pp, 8'hf0);
    end_sim();
  end
  initial begin
    cyc(60000);
    num_errors++;
    end_sim();
  end
endmodule // pxa_top_tb
